// *** rtl/pbs_pkg.sv ***
// Constants for the bus status register block
package pbs_pkg;
  // ****************************************************************
  // Register map
  // ****************************************************************
  localparam logic [7:0]  STATUS_OFFSET = 8'h06;
  localparam logic [15:0] STATUS_RESET  = 16'h0210;

  // ****************************************************************
  // Field positions
  // ****************************************************************
  localparam int BIT_DETECTED_PARITY   = 15;
  localparam int BIT_SIGNALED_SIGNALED_SYSTEM_ERROR_FLAG  = 14;
  localparam int BIT_RCVD_MASTER_ABORT = 13;
  localparam int BIT_RCVD_TARGET_ABORT = 12;
  localparam int BIT_SIG_TARGET_ABORT  = 11;
  localparam int BIT_DEVSEL_HI         = 10;
  localparam int BIT_DEVSEL_LO         = 9;
  localparam int BIT_MASTER_DATA_PAR   = 8;
  localparam int BIT_BACK_TO_BACK      = 7;
  localparam int BIT_USER_FEATURE      = 6;
  localparam int BIT_DOUBLE_SPEED      = 5;
  localparam int BIT_CAP_LIST          = 4;
  localparam int BIT_INT_STATUS        = 3;
  localparam int FLAG_COUNT            = 6;

  // ****************************************************************
  // Hardwired field values
  // ****************************************************************
  localparam logic [1:0] DEVSEL_MEDIUM         = 2'h1;
  localparam logic       BACK_TO_BACK_CAPABLE  = 1'h0;
  localparam logic       USER_FEATURE_SUPPORT  = 1'h0;
  localparam logic       DOUBLE_SPEED_CAPABLE  = 1'h0;
  localparam logic       CAP_LIST_PRESENT      = 1'h1;
  localparam logic [2:0] RESERVED_LOW          = 3'h0;
endpackage

// *** rtl/pbs_sticky_flag.sv ***
// One hardware-set, write-one-to-clear status flag
`timescale 1ns/1ps
`default_nettype none
module pbs_sticky_flag (
  input  wire logic mclk,   // Clock
  input  wire logic rst_n,  // Synchronous reset, active low
  input  wire logic ce,     // Clock enable
  input  wire logic setEv,  // Hardware event
  input  wire logic clrEv,  // Software write-one clear
  output logic      flag    // Sticky flag
);
  logic flag_reg;
  logic flag_next;

  // Set beats clear so an event in the clearing cycle is kept
  always_comb begin
    flag_next = flag_reg;
    if (ce) begin
      if (setEv) begin
        flag_next = 1'b1;
      end else if (clrEv) begin
        flag_next = 1'b0;
      end
    end
  end

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      flag_reg <= 1'b0;
    end else begin
      flag_reg <= flag_next;
    end
  end

  assign flag = flag_reg;
endmodule
`default_nettype wire

// *** rtl/pbs_bus_status.sv ***
// Bus status register with error flags, fixed fields and interrupt pin
//
// Behaviour
// - Set detected-parity on address or data parity.
// - Set system-error flag when enabled error signaled.
// - Set master-abort flag on own aborted cycle.
// - Set target-abort flag when target aborts ours.
// - Set signaled-target-abort when we target-abort.
// - Device select timing reads fixed medium 01b.
// - Data parity flag needs PERR, mastership, enable.
// - Bits seven, six, five read zero.
// - Bit four reads one, capability list.
// - Bit three mirrors interrupt; pin gated by disable.
// - Interrupt disable never alters bit three.
// - Bits two to zero read zero, unwritable.
`timescale 1ns/1ps
`default_nettype none
module pbs_bus_status (
  input  wire logic        mclk,                // Clock, 200 MHz
  input  wire logic        rst_n,               // Synchronous reset
  input  wire logic        ce,                  // Clock enable
  input  wire logic        cfgWrEn,             // Config write strobe
  input  wire logic        cfgRdEn,             // Config read strobe
  input  wire logic [7:0]  cfgAddr,             // Config byte offset
  input  wire logic [1:0]  cfgByteEn,           // Byte enables
  input  wire logic [15:0] cfgWrData,           // Config write data
  output logic      [15:0] cfgRdData,           // Config read data
  output logic             cfgRdValid,          // Read data valid
  input  wire logic        parityErrDetected,   // Address or data parity
  input  wire logic        sysErrSignaled,      // System error reported
  input  wire logic        serrEnable,          // Command bit 8
  input  wire logic        masterAbortRcvd,     // Own cycle master abort
  input  wire logic        targetAbortRcvd,     // Own cycle target abort
  input  wire logic        targetAbortSignaled, // We ended with abort
  input  wire logic        perrSeen,            // PERR asserted by anyone
  input  wire logic        busMasterPhase,      // We mastered the phase
  input  wire logic        parityResponseEnable,// Command bit 6
  input  wire logic        interruptPending,    // Function interrupt
  input  wire logic        interruptDisable,    // Command bit 10
  output logic             intxOut,             // Interrupt pin level
  output logic             intxOe               // Interrupt pin enable
);
  // ****************************************************************
  // Event and clear decode
  // ****************************************************************
  logic [pbs_pkg::FLAG_COUNT-1:0] setVec;
  logic [pbs_pkg::FLAG_COUNT-1:0] clrVec;
  logic [pbs_pkg::FLAG_COUNT-1:0] flagVec;
  logic                           statusHit;
  logic                           clrStrobe;
  logic [15:0]                    statusValue;

  assign statusHit = (cfgAddr == pbs_pkg::STATUS_OFFSET);
  // All clearable flags live in the upper byte
  assign clrStrobe = cfgWrEn && statusHit && cfgByteEn[1];

  always_comb begin
    setVec[5] = parityErrDetected;
    setVec[4] = sysErrSignaled && serrEnable;
    setVec[3] = masterAbortRcvd;
    setVec[2] = targetAbortRcvd;
    setVec[1] = targetAbortSignaled;
    setVec[0] = perrSeen && busMasterPhase
                && parityResponseEnable;
    clrVec[5] = clrStrobe
                && cfgWrData[pbs_pkg::BIT_DETECTED_PARITY];
    clrVec[4] = clrStrobe
                && cfgWrData[pbs_pkg::BIT_SIGNALED_SIGNALED_SYSTEM_ERROR_FLAG];
    clrVec[3] = clrStrobe
                && cfgWrData[pbs_pkg::BIT_RCVD_MASTER_ABORT];
    clrVec[2] = clrStrobe
                && cfgWrData[pbs_pkg::BIT_RCVD_TARGET_ABORT];
    clrVec[1] = clrStrobe
                && cfgWrData[pbs_pkg::BIT_SIG_TARGET_ABORT];
    clrVec[0] = clrStrobe
                && cfgWrData[pbs_pkg::BIT_MASTER_DATA_PAR];
  end

  // ****************************************************************
  // Sticky flags
  // ****************************************************************
  genvar gi;
  generate
    for (gi = 0; gi < pbs_pkg::FLAG_COUNT; gi++) begin : gFlag
      pbs_sticky_flag uFlag (
        .mclk  (mclk),
        .rst_n (rst_n),
        .ce    (ce),
        .setEv (setVec[gi]),
        .clrEv (clrVec[gi]),
        .flag  (flagVec[gi])
      );
    end
  endgenerate

  // ****************************************************************
  // Register image
  // ****************************************************************
  // Fixed fields are constants, so writes to them cannot land
  always_comb begin
    statusValue = 16'h0000;
    statusValue[pbs_pkg::BIT_DETECTED_PARITY]   = flagVec[5];
    statusValue[pbs_pkg::BIT_SIGNALED_SIGNALED_SYSTEM_ERROR_FLAG]  = flagVec[4];
    statusValue[pbs_pkg::BIT_RCVD_MASTER_ABORT] = flagVec[3];
    statusValue[pbs_pkg::BIT_RCVD_TARGET_ABORT] = flagVec[2];
    statusValue[pbs_pkg::BIT_SIG_TARGET_ABORT]  = flagVec[1];
    statusValue[pbs_pkg::BIT_DEVSEL_HI:pbs_pkg::BIT_DEVSEL_LO] =
      pbs_pkg::DEVSEL_MEDIUM;
    statusValue[pbs_pkg::BIT_MASTER_DATA_PAR]   = flagVec[0];
    statusValue[pbs_pkg::BIT_BACK_TO_BACK] =
      pbs_pkg::BACK_TO_BACK_CAPABLE;
    statusValue[pbs_pkg::BIT_USER_FEATURE] =
      pbs_pkg::USER_FEATURE_SUPPORT;
    statusValue[pbs_pkg::BIT_DOUBLE_SPEED] =
      pbs_pkg::DOUBLE_SPEED_CAPABLE;
    statusValue[pbs_pkg::BIT_CAP_LIST] = pbs_pkg::CAP_LIST_PRESENT;
    // Live mirror, independent of the disable control
    statusValue[pbs_pkg::BIT_INT_STATUS] = interruptPending;
    statusValue[2:0] = pbs_pkg::RESERVED_LOW;
  end

  // ****************************************************************
  // Read port and interrupt pin
  // ****************************************************************
  logic [15:0] rdData_reg;
  logic [15:0] rdData_next;
  logic        rdValid_reg;
  logic        rdValid_next;
  logic        intxOe_reg;
  logic        intxOe_next;

  always_comb begin
    rdData_next  = rdData_reg;
    rdValid_next = rdValid_reg;
    intxOe_next  = intxOe_reg;
    if (ce) begin
      rdValid_next = cfgRdEn;
      if (cfgRdEn) begin
        // Unmapped offsets answer with zero
        rdData_next = statusHit ? statusValue : 16'h0000;
      end
      intxOe_next = interruptPending && !interruptDisable;
    end
  end

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      rdData_reg  <= 16'h0000;
      rdValid_reg <= 1'b0;
      intxOe_reg  <= 1'b0;
    end else begin
      rdData_reg  <= rdData_next;
      rdValid_reg <= rdValid_next;
      intxOe_reg  <= intxOe_next;
    end
  end

  assign cfgRdData  = rdData_reg;
  assign cfgRdValid = rdValid_reg;
  // Open drain: the pin only ever pulls low
  assign intxOut    = 1'b0;
  assign intxOe     = intxOe_reg;

  // ****************************************************************
  // Assertions
  // ****************************************************************
  AST_PARITY_SET: assert property (@(posedge mclk)
    disable iff (!rst_n)
    ce && parityErrDetected |=> statusValue[15])
    else $error("parity flag not set");
  AST_SERR_GATED: assert property (@(posedge mclk)
    disable iff (!rst_n)
    ce && !statusValue[14] && !(sysErrSignaled && serrEnable)
    |=> !statusValue[14])
    else $error("system error flag set without enabled error");
  AST_SERR_SET: assert property (@(posedge mclk)
    disable iff (!rst_n)
    ce && sysErrSignaled && serrEnable |=> statusValue[14])
    else $error("system error flag not set");
  AST_RECEIVED_MASTER_ABORT_FLAG_SET: assert property (@(posedge mclk)
    disable iff (!rst_n)
    ce && masterAbortRcvd |=> statusValue[13])
    else $error("master abort flag not set");
  AST_TABORT_RCV: assert property (@(posedge mclk)
    disable iff (!rst_n)
    ce && targetAbortRcvd |=> statusValue[12])
    else $error("received target abort flag not set");
  AST_SIGNALED_TARGET_ABORT_FLAG: assert property (@(posedge mclk)
    disable iff (!rst_n)
    ce && targetAbortSignaled |=> statusValue[11])
    else $error("signaled target abort flag not set");
  AST_DEVSEL_FIXED: assert property (@(posedge mclk)
    disable iff (!rst_n)
    statusValue[10:9] == pbs_pkg::DEVSEL_MEDIUM)
    else $error("device select timing field wrong");
  AST_FIXED_FIELDS: assert property (@(posedge mclk)
    disable iff (!rst_n)
    statusValue[7:4] == 4'h1 && statusValue[2:0] == 3'h0)
    else $error("fixed fields wrong");
  AST_DPAR_GATED: assert property (@(posedge mclk)
    disable iff (!rst_n)
    ce && !statusValue[8]
    && !(perrSeen && busMasterPhase && parityResponseEnable)
    |=> !statusValue[8])
    else $error("data parity flag set without all conditions");
  AST_DPAR_SET: assert property (@(posedge mclk)
    disable iff (!rst_n)
    ce && perrSeen && busMasterPhase && parityResponseEnable
    |=> statusValue[8])
    else $error("data parity flag not set");
  AST_INT_PIN: assert property (@(posedge mclk)
    disable iff (!rst_n)
    ce |=> intxOe == ($past(interruptPending) && !$past(interruptDisable)))
    else $error("interrupt pin not gated by disable");
  AST_INT_MIRROR: assert property (@(posedge mclk)
    disable iff (!rst_n)
    interruptDisable |-> statusValue[3] == interruptPending)
    else $error("interrupt status altered by disable");
  AST_STICKY: assert property (@(posedge mclk)
    disable iff (!rst_n)
    statusValue[15] && !(ce && clrVec[5]) |=> statusValue[15])
    else $error("parity flag lost without clear");
  AST_CLEAR: assert property (@(posedge mclk)
    disable iff (!rst_n)
    ce && clrVec[2] && !setVec[2] |=> !statusValue[12])
    else $error("write one did not clear flag");
  AST_SET_WINS: assert property (@(posedge mclk)
    disable iff (!rst_n)
    ce && setVec[5] && clrVec[5] |=> statusValue[15])
    else $error("clear beat a simultaneous parity event");
  // Flags must hold while the clock enable is low
  AST_CE_FREEZE: assert property (@(posedge mclk)
    disable iff (!rst_n)
    !ce |=> flagVec == $past(flagVec))
    else $error("flags moved while clock enable low");
  AST_RESET_VAL: assert property (@(posedge mclk)
    disable iff (!rst_n)
    $rose(rst_n) |-> (statusValue & 16'hfff7) == pbs_pkg::STATUS_RESET)
    else $error("reset value wrong");
endmodule
`default_nettype wire

// *** tb/pbs_bus_agent.sv ***
// Behavioural model of the other bus agents that raise error events
`timescale 1ns/1ps
`default_nettype none
module pbs_bus_agent (
  input  wire logic       mclk,                // Clock
  input  wire logic       fire,                // Launch one event cycle
  input  wire logic [6:0] evMask,              // Events to raise
  output logic            parityErrDetected,   // Parity error seen
  output logic            sysErrSignaled,      // System error reported
  output logic            masterAbortRcvd,     // Own cycle master abort
  output logic            targetAbortRcvd,     // Own cycle target abort
  output logic            targetAbortSignaled, // We ended with abort
  output logic            perrSeen,            // PERR from any agent
  output logic            busMasterPhase       // We mastered the phase
);
  // Events last one cycle only, so a sticky flag cannot ride on a level
  always_ff @(posedge mclk) begin
    {parityErrDetected, sysErrSignaled, masterAbortRcvd, targetAbortRcvd,
     targetAbortSignaled, perrSeen, busMasterPhase} <= fire ? evMask : 7'h00;
  end
endmodule
`default_nettype wire

// *** tb/testbench.sv ***
// Self-checking bench for the bus status register
`timescale 1ns/1ps
`default_nettype none
module testbench;
  logic        mclk = 1'b0;
  logic        rst_n = 1'b0;
  logic        cfgWrEn = 1'b0;
  logic        cfgRdEn = 1'b0;
  logic [7:0]  cfgAddr = 8'h06;
  logic [1:0]  cfgByteEn = 2'h0;
  logic [15:0] cfgWrData = 16'h0000;
  logic [15:0] cfgRdData;
  logic        cfgRdValid, intxOut, intxOe;
  logic        parityErrDetected, sysErrSignaled, masterAbortRcvd;
  logic        targetAbortRcvd, targetAbortSignaled, perrSeen, busMasterPhase;
  logic        serrEnable = 1'b0;
  logic        parityResponseEnable = 1'b0;
  logic        interruptPending = 1'b0;
  logic        interruptDisable = 1'b0;
  logic        ce = 1'b1;
  logic        fire = 1'b0;
  logic [6:0]  evMask = 7'h00;
  logic [15:0] base;
  int          nMismatch = 0;
  int          nCompared = 0;

  always #2.5 mclk = ~mclk;

  pbs_bus_status uut (.mclk, .rst_n, .ce, .cfgWrEn, .cfgRdEn, .cfgAddr,
    .cfgByteEn, .cfgWrData, .cfgRdData, .cfgRdValid, .parityErrDetected,
    .sysErrSignaled, .serrEnable, .masterAbortRcvd, .targetAbortRcvd,
    .targetAbortSignaled, .perrSeen, .busMasterPhase, .parityResponseEnable,
    .interruptPending, .interruptDisable, .intxOut, .intxOe);

  pbs_bus_agent agent (.mclk, .fire, .evMask, .parityErrDetected,
    .sysErrSignaled, .masterAbortRcvd, .targetAbortRcvd, .targetAbortSignaled,
    .perrSeen, .busMasterPhase);

  // ****************************************************************
  // Access tasks
  // ****************************************************************
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    nCompared++;
    if (seen !== exp) begin
      nMismatch++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic rd(input logic [7:0] a, input logic [15:0] exp);
    @(posedge mclk);
    cfgRdEn <= 1'b1;
    cfgAddr <= a;
    @(posedge mclk);
    cfgRdEn <= 1'b0;
    #1;
    chk({15'h0000, cfgRdValid}, 16'h0001);
    chk(cfgRdData, exp);
  endtask

  task automatic wr(input logic [7:0] a, input logic [1:0] be,
                    input logic [15:0] d);
    @(posedge mclk);
    cfgWrEn <= 1'b1;
    cfgAddr <= a;
    cfgByteEn <= be;
    cfgWrData <= d;
    @(posedge mclk);
    cfgWrEn <= 1'b0;
  endtask

  task automatic ev(input logic [6:0] m);
    @(posedge mclk);
    fire <= 1'b1;
    evMask <= m;
    @(posedge mclk);
    fire <= 1'b0;
  endtask

  task automatic print_verdict;
    $display("compared %0d mismatches %0d", nCompared, nMismatch);
    if (nMismatch == 0 && nCompared > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  // ****************************************************************
  // Tests
  // ****************************************************************
  initial begin
    base = pbs_pkg::STATUS_RESET;
    repeat (6) @(posedge mclk);
    rst_n <= 1'b1;
    rd(8'h06, base);
    rd(8'h08, 16'h0000);
    wr(8'h06, 2'h3, 16'hffff);
    rd(8'h06, base);
    ev(7'h20);
    rd(8'h06, base);
    @(posedge mclk) serrEnable <= 1'b1;
    for (int i = 0; i < 5; i++) begin
      ev(7'h40 >> i);
      rd(8'h06, base | (16'h8000 >> i));
      wr(8'h06, 2'h3, 16'h0000);
      rd(8'h06, base | (16'h8000 >> i));
      wr(8'h06, 2'h2, 16'h8000 >> i);
      rd(8'h06, base);
    end
    // Only all three qualifiers together may raise the data parity flag
    for (int j = 0; j < 8; j++) begin
      @(posedge mclk) parityResponseEnable <= j[2];
      ev({5'h00, j[1:0]});
      rd(8'h06, base | ((j == 7) ? 16'h0100 : 16'h0000));
      wr(8'h06, 2'h2, 16'h0100);
    end
    // Parity event and its clear land on the same edge: the set must win
    @(posedge mclk) begin
      fire <= 1'b1;
      evMask <= 7'h40;
    end
    @(posedge mclk) begin
      fire <= 1'b0;
      cfgWrEn <= 1'b1;
      cfgByteEn <= 2'h2;
      cfgWrData <= 16'h8000;
    end
    @(posedge mclk) cfgWrEn <= 1'b0;
    rd(8'h06, base | 16'h8000);
    // A clear issued while the clock enable is low must not land
    @(posedge mclk) ce <= 1'b0;
    wr(8'h06, 2'h2, 16'h8000);
    @(posedge mclk) ce <= 1'b1;
    rd(8'h06, base | 16'h8000);
    wr(8'h06, 2'h2, 16'h8000);
    rd(8'h06, base);
    @(posedge mclk) interruptPending <= 1'b1;
    rd(8'h06, base | 16'h0008);
    chk({15'h0000, intxOe}, 16'h0001);
    @(posedge mclk) interruptDisable <= 1'b1;
    rd(8'h06, base | 16'h0008);
    chk({15'h0000, intxOe}, 16'h0000);
    chk({15'h0000, intxOut}, 16'h0000);
    wr(8'h06, 2'h3, 16'h0008);
    rd(8'h06, base | 16'h0008);
    // A second reset in mid-run must drop flags raised before it
    ev(7'h10);
    @(posedge mclk) rst_n <= 1'b0;
    @(posedge mclk) rst_n <= 1'b1;
    rd(8'h06, base | 16'h0008);
    print_verdict();
  end

  initial begin
    #50000;
    nMismatch++;
    print_verdict();
  end
endmodule
`default_nettype wire
